// file: logic/reset_cause_and_part_id.sv
// top of the reset cause and part identification register block
// assumes: i_nrst is an always-on reset released once at power-up;
// the recorded reset sources do not reset this block
//
// Summary of operation
// - part id word readable in bits 31 to 0
// - part id fixed per variant, unique
// - cause flags remember every reset source since last cleared
// - core-only reset control sets flag bit 7
// - core system reset request sets bit 5
// - brown-out reset sets bit 4, else 0
// - low-voltage reset sets flag bit 3
// - write 1 clears bits 7,5,4; 0 keeps
// - write 1 clears low-voltage flag too
// - watchdog reset sets bit 2, W1C
// - reset pin sets bit 1, W1C
// - power-on or chip reset sets bit 0
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rstcause_consts.svh"
module reset_cause_and_part_id
  import rstcause_pkg::*;
#(
  parameter logic [31:0] PART_ID = `PART_ID_DFLT  // arbitrary value
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // avalon-mm slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // reset source requests, asynchronous levels
  input  wire logic        i_core_only_rst,
  input  wire logic        i_core_sys_req,
  input  wire logic        i_brownout_rst,
  input  wire logic        i_low_volt_rst,
  input  wire logic        i_watchdog_rst,
  input  wire logic        i_pin_rst,
  input  wire logic        i_power_on_rst,
  input  wire logic        i_chip_rst,
  // interrupt
  output logic             o_irq
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  rstcause_evt_if evt ();        // synchronised event pulses

  bus_st_e  state_r;             // bus slave state
  logic [31:0] rdata_r;          // registered read data
  flags_t   cause_r;             // reset cause flags
  flags_t   cause_nxt;           // next cause flags
  flags_t   cause_clr;           // write-one-to-clear mask
  flags_t   irq_stat_r;          // sticky interrupt status
  flags_t   irq_stat_nxt;        // next interrupt status
  flags_t   irq_clr;             // interrupt clear mask
  flags_t   irq_en_r;            // interrupt enables
  flags_t   evt_set;             // events at flag positions
  logic     irq_r;               // registered interrupt level
  logic     rd_take;             // read sampled this edge
  logic     wr_acc;              // write takes effect this edge
  logic [31:0] rd_nxt;           // read data mux

  // ******************************************************************
  // event mapping
  // ******************************************************************
  // places the event vector on the flag layout, bit 6 stays zero
  function automatic flags_t expand_evt(input logic [6:0] e);
    expand_evt = {e[6], 1'b0, e[5:0]};
  endfunction

  // power-on and chip reset share one flag
  reset_event_sync #(
    .N (`EVT_CNT)
  ) reset_event_sync_inst (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_src     ({i_core_only_rst, i_core_sys_req, i_brownout_rst,
                 i_low_volt_rst, i_watchdog_rst, i_pin_rst,
                 i_power_on_rst | i_chip_rst}),
    .evt       (evt.src)
  );

  assign evt_set = expand_evt(evt.pulse);

  // ******************************************************************
  // bus slave
  // ******************************************************************
  // first edge of a request loads read data, second completes it
  assign rd_take = (state_r == ST_IDLE) && i_read;
  assign wr_acc  = (state_r == ST_ACK) && i_write;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // answer any request one cycle later
          if (i_read || i_write) begin
            state_r <= ST_ACK;
          end
        end
        ST_ACK: begin
          // master samples waitrequest low here
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // waitrequest is the idle bit of the one-hot state
  assign o_waitrequest = state_r[0];

  // read data mux, unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (i_address)
      `OFS_PART_ID:  rd_nxt = PART_ID;
      `OFS_CAUSE:    rd_nxt = {24'h00_0000, cause_r};
      `OFS_IRQ_STAT: rd_nxt = {24'h00_0000, irq_stat_r};
      `OFS_IRQ_EN:   rd_nxt = {24'h00_0000, irq_en_r};
      default:       rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured on the first edge, held through the answer
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rd_nxt;
    end
  end

  assign o_readdata = rdata_r;

  // ******************************************************************
  // reset cause flags
  // ******************************************************************
  // only byte lane 0 holds flags
  assign cause_clr = (wr_acc && i_address == `OFS_CAUSE &&
                      i_byteenable[0]) ? i_writedata[7:0] : 8'h00;

  // set wins over a clear in the same cycle
  assign cause_nxt = ((cause_r & ~cause_clr) | evt_set)
                     & `CAUSE_LIVE_MASK;

  // the power-up reset is itself a recorded power-on reset
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cause_r <= `CAUSE_RST_VAL;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ******************************************************************
  // interrupt status, clear and enable
  // ******************************************************************
  assign irq_clr = (wr_acc && i_address == `OFS_IRQ_CLR &&
                    i_byteenable[0]) ? i_writedata[7:0] : 8'h00;

  assign irq_stat_nxt = ((irq_stat_r & ~irq_clr) | evt_set)
                        & `CAUSE_LIVE_MASK;

  // sticky event status
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_r <= `IRQ_RST_VAL;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // enable register, same layout as status
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_en_r <= `IRQ_RST_VAL;
    end else if (wr_acc && i_address == `OFS_IRQ_EN &&
                 i_byteenable[0]) begin
      irq_en_r <= i_writedata[7:0] & `CAUSE_LIVE_MASK;
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  assign o_irq = irq_r;

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_rd_at(logic [7:0] ofs);
    (state_r == ST_IDLE) && i_read && (i_address == ofs);
  endsequence

  sequence s_wr_at(logic [7:0] ofs);
    (state_r == ST_ACK) && i_write && (i_address == ofs);
  endsequence

  chk_id_read_value: assert property (
    s_rd_at(`OFS_PART_ID) |=> !o_waitrequest && o_readdata == PART_ID
  ) else $error("part id read wrong");

  chk_id_write_ignored: assert property (
    s_wr_at(`OFS_PART_ID) ##2 s_rd_at(`OFS_PART_ID)
      |=> o_readdata == PART_ID
  ) else $error("part id changed by write");

  chk_cause_read_back: assert property (
    s_rd_at(`OFS_CAUSE) |=> o_readdata == {24'h00_0000, $past(cause_r)}
  ) else $error("cause read mismatch");

  chk_core_only_set: assert property (
    evt.pulse[6] |=> cause_r[`BIT_CORE_ONLY]
  ) else $error("core-only flag not set");

  chk_core_req_set: assert property (
    evt.pulse[5] |=> cause_r[`BIT_CORE_REQ]
  ) else $error("core request flag not set");

  chk_brownout_flag: assert property (
    evt.pulse[4] |=> cause_r[`BIT_BROWNOUT] ##1 cause_r[`BIT_BROWNOUT]
      || $past(cause_clr[`BIT_BROWNOUT])
  ) else $error("brownout flag wrong");

  chk_brownout_quiet: assert property (
    !evt.pulse[4] && !cause_r[`BIT_BROWNOUT] |=> !cause_r[`BIT_BROWNOUT]
  ) else $error("brownout flag set without cause");

  chk_low_volt_set: assert property (
    evt.pulse[3] |=> cause_r[`BIT_LOW_VOLT]
  ) else $error("low voltage flag not set");

  chk_w1c_clears: assert property (
    s_wr_at(`OFS_CAUSE) and (i_byteenable[0]
      && (i_writedata[7:0] & 8'hB0) == 8'hB0
      && !evt.pulse[6] && !evt.pulse[5] && !evt.pulse[4])
      |=> cause_r[7] == 1'b0 && cause_r[5:4] == 2'b00
  ) else $error("write one did not clear");

  chk_w0_keeps: assert property (
    s_wr_at(`OFS_CAUSE) and (i_writedata[7:0] == 8'h00)
      |=> $stable(cause_r)
      || (cause_r & ~$past(cause_r)) == $past(evt_set & ~cause_r)
  ) else $error("write zero changed flags");

  chk_low_volt_clear: assert property (
    s_wr_at(`OFS_CAUSE) and (i_byteenable[0] && i_writedata[3]
      && !evt.pulse[3]) |=> !cause_r[`BIT_LOW_VOLT]
  ) else $error("low voltage flag not cleared");

  chk_watchdog_set: assert property (
    evt.pulse[2] |=> cause_r[`BIT_WATCHDOG]
  ) else $error("watchdog flag not set");

  chk_pin_set: assert property (
    evt.pulse[1] |=> cause_r[`BIT_PIN]
  ) else $error("pin flag not set");

  chk_power_on_set: assert property (
    evt.pulse[0] |=> cause_r[`BIT_POWER_ON]
  ) else $error("power-on flag not set");

  chk_reserved_bit6: assert property (
    !cause_r[6]
  ) else $error("reserved flag bit set");

  chk_reserved_high: assert property (
    s_rd_at(`OFS_CAUSE) |=> o_readdata[31:8] == 24'h00_0000
  ) else $error("reserved bits not zero");

  chk_flags_persist: assert property (
    1'b1 |=> ($past(cause_r & ~cause_clr) & ~cause_r) == 8'h00
  ) else $error("flag lost without clear");

  chk_irq_level: assert property (
    |(irq_stat_r & irq_en_r) |=> o_irq
  ) else $error("interrupt not raised");

  // no enabled status bit means the level drops one edge later
  chk_irq_quiet: assert property (
    !(|(irq_stat_r & irq_en_r)) |=> !o_irq
  ) else $error("interrupt raised without cause");

  // every event lands in the sticky status on the next edge
  chk_irq_stat_set: assert property (
    |evt_set |=> (irq_stat_r & $past(evt_set)) == $past(evt_set)
  ) else $error("interrupt status not set");

  // each request gets exactly one wait cycle, then idle again
  chk_wait_one: assert property (
    (state_r == ST_IDLE) && (i_read || i_write)
      |=> !o_waitrequest ##1 o_waitrequest
  ) else $error("wait cycle count wrong");

endmodule // reset_cause_and_part_id

// file: logic/rstcause_consts.svh
// constants for the reset cause and part identification block
// assumes: included by bare name from the logic/ files of this block
`ifndef RSTCAUSE_CONSTS_SVH
`define RSTCAUSE_CONSTS_SVH

// ********************************************************************
// register byte offsets (one aligned 32-bit word each)
// ********************************************************************
`define OFS_PART_ID   8'h00
`define OFS_CAUSE     8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_CLR   8'h0C
`define OFS_IRQ_EN    8'h10

// ********************************************************************
// reset cause flag positions
// ********************************************************************
`define BIT_CORE_ONLY 7
`define BIT_CORE_REQ  5
`define BIT_BROWNOUT  4
`define BIT_LOW_VOLT  3
`define BIT_WATCHDOG  2
`define BIT_PIN       1
`define BIT_POWER_ON  0

// ********************************************************************
// reset values and masks
// ********************************************************************
`define CAUSE_LIVE_MASK 8'hBF
`define CAUSE_RST_VAL   8'h01
`define IRQ_RST_VAL     8'h00
`define PART_ID_DFLT    32'h0000_5A3C
`define EVT_CNT         7

`endif

// file: logic/rstcause_pkg.sv
// types shared by the reset cause and part identification block
// assumes: compiled before every other file of the block
package rstcause_pkg;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_st_e;

  // one byte of reset cause or interrupt flags
  typedef logic [7:0] flags_t;

endpackage

// file: logic/rstcause_evt_if.sv
// carrier for reset source event pulses between the two modules
// assumes: one clock domain, pulses last one cycle
`timescale 1ns/1ps
interface rstcause_evt_if;
  logic [6:0] pulse;  // one-cycle event per reset source

  modport src (output pulse);
  modport dst (input  pulse);
endinterface

// file: logic/reset_event_sync.sv
// synchroniser and edge detector for the reset source inputs
// assumes: sources are asynchronous levels, high while asserted
`timescale 1ns/1ps
`include "rstcause_consts.svh"
module reset_event_sync
  import rstcause_pkg::*;
#(
  parameter int N = `EVT_CNT
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic [N-1:0] i_src,
  rstcause_evt_if.src       evt
);

  logic [N-1:0] meta_r;  // first stage, read only by the second
  logic [N-1:0] sync_r;  // second stage, safe to use
  logic [N-1:0] prev_r;  // delayed copy for edge detect

  // ******************************************************************
  // two-stage synchroniser plus delay
  // ******************************************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= i_src;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // rising edge of a source becomes a one-cycle pulse
  assign evt.pulse = sync_r & ~prev_r;

endmodule // reset_event_sync

// file: verif/reset_cause_and_part_id_tb.sv
// testbench for the reset cause and part identification block
// assumes: avalon-mm slave with one wait cycle, sources edge-detected
`timescale 1ns/1ps
`include "rstcause_consts.svh"
module reset_cause_and_part_id_tb;
  import rstcause_pkg::*;

  // part id chosen for this bench, the value is arbitrary
  localparam logic [31:0] ID_VAL = 32'h0000_3C96;
  localparam int          TMO    = 50;  // bus wait bound in cycles

  logic        i_clk_sys;     // system clock
  logic        i_nrst;        // async reset, active low
  logic [7:0]  i_address;     // bus byte address
  logic        i_read;        // bus read strobe
  logic        i_write;       // bus write strobe
  logic [3:0]  i_byteenable;  // bus byte lanes
  logic [31:0] i_writedata;   // bus write data
  logic [31:0] o_readdata;    // bus read data
  logic        o_waitrequest; // bus stall
  logic        o_irq;         // interrupt level
  logic [7:0]  src;           // sources, index 6 is the chip reset
  int          n_fail;        // mismatches seen
  int          num_checks;    // comparisons made
  logic [31:0] rd;            // last read word
  logic [31:0] exp;           // expected cause word

  // ******************************************************************
  // clock and design
  // ******************************************************************
  always #10 i_clk_sys = ~i_clk_sys;

  reset_cause_and_part_id #(.PART_ID(ID_VAL)) reset_cause_and_part_id_inst (
    .i_clk_sys       (i_clk_sys),
    .i_nrst          (i_nrst),
    .i_address       (i_address),
    .i_read          (i_read),
    .i_write         (i_write),
    .i_byteenable    (i_byteenable),
    .i_writedata     (i_writedata),
    .o_readdata      (o_readdata),
    .o_waitrequest   (o_waitrequest),
    .i_core_only_rst (src[7]),
    .i_core_sys_req  (src[5]),
    .i_brownout_rst  (src[4]),
    .i_low_volt_rst  (src[3]),
    .i_watchdog_rst  (src[2]),
    .i_pin_rst       (src[1]),
    .i_power_on_rst  (src[0]),
    .i_chip_rst      (src[6]),
    .o_irq           (o_irq)
  );

  // ******************************************************************
  // helper tasks
  // ******************************************************************
  // verdict and end of run
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] wd);
    int k;
    @(posedge i_clk_sys);
    i_address    <= a;
    i_byteenable <= be;
    i_writedata  <= wd;
    i_read       <= ~wr;
    i_write      <= wr;
    for (k = 0; k < TMO; k++) begin
      @(posedge i_clk_sys);
      if (o_waitrequest === 1'b0) break;
    end
    if (k == TMO) begin
      n_fail++;
      results();
    end else begin
      rd = o_readdata;
      i_read  <= 1'b0;
      i_write <= 1'b0;
    end
  endtask

  // read a register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 4'hF, 32'h0);
    chk(rd, want);
  endtask

  // one source rise, held, then low long enough to be seen again
  task automatic pulse(input int idx);
    @(posedge i_clk_sys);
    src[idx] <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    src[idx] <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    i_clk_sys = 1'b0;
    i_nrst = 1'b0;
    {i_address, i_read, i_write} = '0;
    i_byteenable = 4'h0;
    i_writedata = 32'h0;
    src = 8'h00;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    // reset values and the read-only id word
    rd_chk(`OFS_PART_ID, ID_VAL);
    rd_chk(`OFS_CAUSE, 32'h0000_0001);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
    rd_chk(`OFS_IRQ_EN, 32'h0);
    bus(1'b1, `OFS_PART_ID, 4'hF, 32'hFFFF_FFFF);
    rd_chk(`OFS_PART_ID, ID_VAL);
    // unmapped place reads zero and ignores writes
    bus(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0);
    // clear all, then each source but the chip reset (index 6) adds its own flag
    bus(1'b1, `OFS_CAUSE, 4'hF, 32'hFFFF_FFFF);
    exp = 32'h0;
    rd_chk(`OFS_CAUSE, exp);
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        pulse(i);
        exp[i] = 1'b1;
        rd_chk(`OFS_CAUSE, exp);
      end
    end
    // zeros and a masked lane leave the flags alone
    bus(1'b1, `OFS_CAUSE, 4'hF, 32'h0);
    rd_chk(`OFS_CAUSE, exp);
    bus(1'b1, `OFS_CAUSE, 4'hE, 32'hFFFF_FFFF);
    rd_chk(`OFS_CAUSE, exp);
    // clear one bit at a time, bit 6 never shows
    for (int b = 0; b < 8; b++) begin
      bus(1'b1, `OFS_CAUSE, 4'hF, 32'h1 << b);
      exp[b] = 1'b0;
      rd_chk(`OFS_CAUSE, exp);
    end
    // chip reset control shares the power-on flag
    pulse(6);
    rd_chk(`OFS_CAUSE, 32'h0000_0001);
    // ****************************************************************
    // interrupt: raise, clear, mask
    // ****************************************************************
    bus(1'b1, `OFS_IRQ_CLR, 4'hF, 32'h0000_00FF);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
    rd_chk(`OFS_IRQ_CLR, 32'h0);
    bus(1'b1, `OFS_IRQ_EN, 4'hF, 32'h0000_00FF);
    rd_chk(`OFS_IRQ_EN, 32'h0000_00BF);
    bus(1'b1, `OFS_IRQ_EN, 4'hF, 32'h0000_0004);
    pulse(2);
    chk({31'h0, o_irq}, 32'h1);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0004);
    bus(1'b1, `OFS_IRQ_CLR, 4'hF, 32'h0000_0004);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    rd_chk(`OFS_CAUSE, 32'h0000_0005);
    // event with its enable off stays quiet
    pulse(1);
    chk({31'h0, o_irq}, 32'h0);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0002);
    results();
  end
endmodule // reset_cause_and_part_id_tb
